// *** src/atsr_engine.sv ***
// time slot record engine for two serial audio ports
// assumes bclk and data lines are asynchronous pins, DMA side on mclk
//
// Summary of operation
// - each word-select line follows its record bit during the slot.
// - lines 0 and 4 ignore the record bit when set as trigger input.
// - input-source code picks the captured data line, 00 port dependent.
// - capture-to-word puts the slot byte in the next word buffer byte.
// - capture-to-feedback puts the slot byte in the next feedback byte.
// - store-word pushes the word buffer into the input FIFO.
// - load-word pops the next output FIFO word into the output buffer.
// - byte-select picks output byte 0-3 or feedback byte 0-3.
// - output-pin code picks the driven data line, 00 port dependent.
// - when both ports pick one line, port one drives it.
// - every data line not driven this slot or held by a low tail is released.
// - low tail drives last slot's line low for seven bit clocks.
// - end-of-superframe makes the next slot use the first record.
// - records are four bytes; up to 32 records, each with fields for both ports.
// - record holds word-select, port one, port two fields and END_OF_SUPERFRAME.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module atsr_engine (
  input  wire logic                                  mclk,
  input  wire logic                                  ce,
  input  wire logic                                  srst,
  input  wire logic [atsr_pkg::ADDR_W-1:0]           regAddr,
  input  wire logic [31:0]                           regWdata,
  input  wire logic                                  regWr,
  input  wire logic                                  regRd,
  output logic      [31:0]                           regRdata,
  input  wire logic                                  bclk,
  input  wire logic [4:0]                            sdIn,
  output logic      [4:0]                            sdOut,
  output logic      [4:0]                            sdOe,
  output logic      [4:0]                            wsOut,
  output logic      [4:0]                            wsOe,
  output logic      [1:0]                            capValid,
  output logic      [1:0][atsr_pkg::WORD_W-1:0]      capData,
  input  wire logic [1:0]                            capReady,
  input  wire logic [1:0]                            playValid,
  input  wire logic [1:0][atsr_pkg::WORD_W-1:0]      playData,
  output logic      [1:0]                            playReady
);
  import atsr_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] pinHot(input logic [1:0] code,
                                        input logic [2:0] zero);
    pinHot = 5'h00;
    if (code == 2'h0) pinHot[zero] = 1'b1;
    else pinHot[code] = 1'b1;
  endfunction : pinHot

  function automatic logic [2:0] pinIdx(input logic [1:0] code,
                                        input logic [2:0] zero);
    pinIdx = (code == 2'h0) ? zero : {1'b0, code};
  endfunction : pinIdx

  function automatic logic [7:0] byteOf(input logic [31:0] w,
                                        input logic [1:0]  i);
    byteOf = w[{i, 3'h0} +: 8];
  endfunction : byteOf

  function automatic logic [31:0] putByte(input logic [31:0] w,
                                          input logic [1:0]  i,
                                          input logic [7:0]  b);
    putByte = w;
    putByte[{i, 3'h0} +: 8] = b;
  endfunction : putByte

  function automatic logic [FLD_W-1:0] portFld(input logic [31:0] r,
                                               input int          p);
    portFld = (p == 0) ? r[P1_LO +: FLD_W] : r[P2_LO +: FLD_W];
  endfunction : portFld

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [4:0] sdMeta_q, sdSync_q;
  logic       bclkMeta_q, bclkSync_q, bclkPrev_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      sdMeta_q   <= 5'h00;
      sdSync_q   <= 5'h00;
      bclkMeta_q <= 1'b0;
      bclkSync_q <= 1'b0;
      bclkPrev_q <= 1'b0;
    end else if (ce) begin
      sdMeta_q   <= sdIn;
      sdSync_q   <= sdMeta_q;
      bclkMeta_q <= bclk;
      bclkSync_q <= bclkMeta_q;
      bclkPrev_q <= bclkSync_q;
    end
  end

  wire bitRise = bclkSync_q & ~bclkPrev_q;

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  logic [REC_W-1:0]  time_slot_list [NUM_REC];
  logic [CTRL_W-1:0] ctrl_q;
  logic [1:0]        ovf_q, unf_q;
  logic [1:0]        ovfSet, unfSet;
  logic [PTR_W-1:0]  ptr_q;
  atsr_state_t       st_q;

  wire        listSel = (regAddr[ADDR_W-1] == 1'b0);
  wire        ctrlSel = (regAddr == ADDR_CTRL);
  wire        statSel = (regAddr == ADDR_STAT);
  wire [1:0]  portEn  = ctrl_q[CTRL_EN2:CTRL_EN1];
  wire [31:0] statVal = {21'h0, st_q, unf_q, ovf_q, ptr_q};
  wire [31:0] rdVal   = ctrlSel ? {28'h0, ctrl_q} :
                        statSel ? statVal : 32'h0;

  always_ff @(posedge mclk) begin
    if (ce && regWr && listSel) time_slot_list[regAddr[PTR_W-1:0]] <= regWdata;
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_q   <= CTRL_RST;
      ovf_q    <= 2'h0;
      unf_q    <= 2'h0;
      regRdata <= 32'h0;
    end else if (ce) begin
      if (regWr && ctrlSel) ctrl_q <= regWdata[CTRL_W-1:0];
      // set beats a write-one clear in the same cycle
      ovf_q <= (ovf_q & ~({2{regWr & statSel}}
                          & regWdata[STAT_OVF +: 2])) | ovfSet;
      unf_q <= (unf_q & ~({2{regWr & statSel}}
                          & regWdata[STAT_UNF +: 2])) | unfSet;
      regRdata <= regRd ? rdVal : 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // slot sequencer
  // ----------------------------------------------------------------
  logic [REC_W-1:0] rec_q;
  logic [2:0]       bitCnt_q;
  wire  [REC_W-1:0] tslRd   = time_slot_list[ptr_q];
  wire              slotEnd = (st_q == ST_SHIFT) & bitRise
                              & (bitCnt_q == LAST_BIT);

  always_ff @(posedge mclk) begin
    if (srst) begin
      st_q     <= ST_IDLE;
      ptr_q    <= '0;
      bitCnt_q <= 3'h0;
      rec_q    <= '0;
    end else if (ce) begin
      case (st_q)
        ST_IDLE: begin
          ptr_q <= '0;
          if (|portEn) st_q <= ST_FETCH;
        end
        ST_FETCH: begin
          rec_q    <= tslRd;
          bitCnt_q <= 3'h0;
          st_q     <= ST_SHIFT;
        end
        ST_SHIFT: begin
          if (bitRise) bitCnt_q <= bitCnt_q + 3'h1;
          if (slotEnd) begin
            if (rec_q[EOS_BIT]) ptr_q <= '0;
            else ptr_q <= ptr_q + 1'b1;
            st_q <= (|portEn) ? ST_FETCH : ST_IDLE;
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // per-port datapath
  // ----------------------------------------------------------------
  logic [1:0][7:0]  inSh_q, outSh_q, capByte, selOut;
  logic [1:0][31:0] wordBuf_q, fbBuf_q, outBuf_q, wordNext;
  logic [1:0][1:0]  wordPos_q, fbPos_q;
  logic [1:0][4:0]  hot, prevHot_q, tailHot_q;
  logic [1:0][2:0]  tailCnt_q;
  logic [1:0]       cw, cf, sw, lw, inBit, capFull, playHave;
  logic [1:0]       lowNext;
  logic [4:0]       drive0, drive1;
  logic [1:0][31:0] playWord;

  for (genvar p = 0; p < 2; p++) begin : g_port
    localparam logic [2:0] IN0  = (p == 0) ? LINE_P1_IN0 : LINE_P2_IN0;
    localparam logic [2:0] OUT0 = (p == 0) ? LINE_P1_OUT0 : LINE_P2_OUT0;
    wire [FLD_W-1:0] f  = portFld(rec_q, p);
    wire [FLD_W-1:0] fN = portFld(tslRd, p);
    wire [2:0]       bs = fN[F_BS +: 3];
    wire             go = slotEnd & portEn[p];

    assign cw[p] = f[F_CW];
    assign cf[p] = f[F_CF];
    assign sw[p] = f[F_SW];
    assign lw[p] = f[F_LW];
    assign lowNext[p] = fN[F_LT];
    assign inBit[p]   = sdSync_q[pinIdx(f[F_IS +: 2], IN0)];
    assign capByte[p] = {inSh_q[p][6:0], inBit[p]};
    assign wordNext[p] = cw[p] ? putByte(wordBuf_q[p], wordPos_q[p],
                                         capByte[p])
                               : wordBuf_q[p];
    assign selOut[p] = bs[2] ? byteOf(fbBuf_q[p], bs[1:0])
                             : byteOf(outBuf_q[p], bs[1:0]);
    assign hot[p] = ((st_q == ST_SHIFT) && portEn[p])
                    ? pinHot(f[F_OP +: 2], OUT0) : 5'h00;

    atsr_stream_if #(.W(WORD_W)) capIn ();
    atsr_stream_if #(.W(WORD_W)) capOut ();
    atsr_stream_if #(.W(WORD_W)) playIn ();
    atsr_stream_if #(.W(WORD_W)) playOut ();

    assign capIn.valid  = go & sw[p];
    assign capIn.data   = wordNext[p];
    assign capFull[p]   = ~capIn.ready;
    assign capValid[p]  = capOut.valid;
    assign capData[p]   = capOut.data;
    assign capOut.ready = capReady[p];
    assign playIn.valid = playValid[p];
    assign playIn.data  = playData[p];
    assign playReady[p] = playIn.ready;
    assign playOut.ready = go & lw[p];
    assign playHave[p]  = playOut.valid;
    assign playWord[p]  = playOut.data;
    assign ovfSet[p]    = capIn.valid & capFull[p];
    assign unfSet[p]    = playOut.ready & ~playHave[p];

    atsr_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_capFifo (
      .mclk  (mclk),
      .ce    (ce),
      .srst  (srst),
      .fill  (capIn),
      .drain (capOut)
    );

    atsr_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_playFifo (
      .mclk  (mclk),
      .ce    (ce),
      .srst  (srst),
      .fill  (playIn),
      .drain (playOut)
    );
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      inSh_q  <= '0;
      outSh_q <= '0;
    end else if (ce) begin
      for (int p = 0; p < 2; p++) begin
        if (st_q == ST_FETCH) begin
          outSh_q[p] <= selOut[p];
        end else if (st_q == ST_SHIFT && bitRise) begin
          inSh_q[p]  <= capByte[p];
          outSh_q[p] <= {outSh_q[p][6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      wordBuf_q <= '0;
      fbBuf_q   <= '0;
      outBuf_q  <= '0;
      wordPos_q <= '0;
      fbPos_q   <= '0;
    end else if (ce) begin
      for (int p = 0; p < 2; p++) begin
        if (slotEnd && portEn[p]) begin
          wordBuf_q[p] <= wordNext[p];
          if (sw[p]) wordPos_q[p] <= 2'h0;
          else if (cw[p]) wordPos_q[p] <= wordPos_q[p] + 2'h1;
          if (cf[p]) begin
            fbBuf_q[p] <= putByte(fbBuf_q[p], fbPos_q[p],
                                  capByte[p]);
            fbPos_q[p] <= fbPos_q[p] + 2'h1;
          end
          if (lw[p] && playHave[p]) outBuf_q[p] <= playWord[p];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // low tail
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      prevHot_q <= '0;
      tailHot_q <= '0;
      tailCnt_q <= {TAIL_BITS, TAIL_BITS};
    end else if (ce) begin
      for (int p = 0; p < 2; p++) begin
        if (st_q == ST_FETCH) begin
          tailHot_q[p] <= prevHot_q[p];
          tailCnt_q[p] <= lowNext[p] ? 3'h0 : TAIL_BITS;
        end else if (bitRise && tailCnt_q[p] != TAIL_BITS) begin
          tailCnt_q[p] <= tailCnt_q[p] + 3'h1;
        end
        if (slotEnd) prevHot_q[p] <= (p == 0) ? drive0 : drive1;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------
  assign drive0 = hot[0];
  assign drive1 = hot[1] & ~hot[0];
  wire [4:0] tailLines =
    ((tailCnt_q[0] != TAIL_BITS) ? tailHot_q[0] : 5'h00) |
    ((tailCnt_q[1] != TAIL_BITS) ? tailHot_q[1] : 5'h00);
  wire [4:0] sdOe_d  = drive0 | drive1 | tailLines;
  wire [4:0] sdOut_d = (drive0 & {5{outSh_q[0][7]}})
                     | (drive1 & {5{outSh_q[1][7]}});
  wire [4:0] wsOe_d  = {~ctrl_q[CTRL_TRIG4], 3'h7,
                        ~ctrl_q[CTRL_TRIG0]};
  wire       run     = (st_q != ST_IDLE);
  logic [4:0] wsRec;

  for (genvar i = 0; i < 5; i++) begin : g_ws
    assign wsRec[i] = rec_q[WS_HI - i];
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      sdOut <= 5'h00;
      sdOe  <= 5'h00;
      wsOut <= 5'h00;
      wsOe  <= 5'h00;
    end else if (ce) begin
      sdOut <= sdOut_d;
      sdOe  <= sdOe_d;
      wsOut <= run ? (wsRec & wsOe_d) : 5'h00;
      wsOe  <= wsOe_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  wire capIn_seen = slotEnd & portEn[0] & sw[0] & ~capFull[0];

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_ws_follows: assert property (ce && run && !ctrl_q[CTRL_TRIG0]
    |=> wsOut[0] == $past(rec_q[WS_HI]))
    else $error("word-select line 0 differs from record");
  a_trig_ignored: assert property (ce && ctrl_q[CTRL_TRIG4]
    |=> !wsOe[4] && !wsOut[4])
    else $error("trigger line 4 driven");
  a_cap_pin: assert property (ce && st_q == ST_SHIFT && bitRise
    && rec_q[P2_LO + F_IS +: 2] == 2'h0
    |=> inSh_q[1][0] == $past(sdSync_q[0]))
    else $error("port two did not capture line 0");
  a_store_word: assert property (ce && slotEnd && portEn[0] && sw[0]
    |=> wordPos_q[0] == 2'h0)
    else $error("word position not reset after store");
  a_load_word: assert property (ce && slotEnd && portEn[0] && lw[0]
    && playHave[0] |=> outBuf_q[0] == $past(playWord[0]))
    else $error("output buffer not loaded");
  a_p1_wins: assert property (ce && hot[0] != 5'h00
    && hot[0] == hot[1]
    |=> (sdOut & $past(hot[0])) ==
        ($past(hot[0]) & {5{$past(outSh_q[0][7])}}))
    else $error("port two drove a shared line");
  a_idle_release: assert property (ce && st_q == ST_IDLE
    && tailLines == 5'h00 |=> sdOe == 5'h00)
    else $error("data line driven while idle");
  a_tail_low: assert property (ce && tailLines != 5'h00
    && drive0 == 5'h00 && drive1 == 5'h00
    |=> (sdOut == 5'h00) && (sdOe == $past(tailLines)))
    else $error("tail line not low");
  a_eos_wrap: assert property (ce && slotEnd && rec_q[EOS_BIT]
    |=> ptr_q == '0 ##1 st_q != ST_FETCH || rec_q == time_slot_list[0])
    else $error("pointer not reset at superframe end");
  a_ptr_step: assert property (ce && slotEnd && !rec_q[EOS_BIT]
    |=> ptr_q == $past(ptr_q) + 1'b1)
    else $error("pointer did not advance");

  c_superframe: cover property (slotEnd && rec_q[EOS_BIT]);
  c_conflict:   cover property (hot[0] != 5'h00 && hot[0] == hot[1]);
  c_tail:       cover property (tailLines != 5'h00 ##1 sdOe != 5'h00);
  c_store:      cover property (capIn_seen);

endmodule : atsr_engine

// *** include/atsr_pkg.sv ***
// constants for the audio time slot record engine
// assumes one system clock; bit clock is sampled as a plain input
package atsr_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_REC    = 32;
  localparam int REC_W      = 32;
  localparam int PTR_W      = 5;
  localparam int ADDR_W     = 6;
  localparam int WORD_W     = 32;
  localparam int FIFO_DEPTH = 4;
  localparam int FLD_W      = 12;
  localparam int CTRL_W     = 4;

  // ----------------------------------------------------------------
  // register port map (word index)
  // ----------------------------------------------------------------
  localparam logic [5:0] ADDR_CTRL = 6'h20;
  localparam logic [5:0] ADDR_STAT = 6'h21;
  localparam int CTRL_EN1   = 0;
  localparam int CTRL_EN2   = 1;
  localparam int CTRL_TRIG0 = 2;
  localparam int CTRL_TRIG4 = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;
  localparam int STAT_PTR = 0;
  localparam int STAT_OVF = 5;
  localparam int STAT_UNF = 7;
  localparam int STAT_ST  = 9;

  // ----------------------------------------------------------------
  // record layout
  // ----------------------------------------------------------------
  localparam int WS_HI   = 31;
  localparam int P1_LO   = 14;
  localparam int P2_LO   = 1;
  localparam int EOS_BIT = 0;
  localparam int F_IS    = 10;
  localparam int F_CW    = 9;
  localparam int F_CF    = 8;
  localparam int F_SW    = 7;
  localparam int F_LW    = 6;
  localparam int F_BS    = 3;
  localparam int F_OP    = 1;
  localparam int F_LT    = 0;

  // ----------------------------------------------------------------
  // pins and timing in bit-clock cycles
  // ----------------------------------------------------------------
  localparam logic [2:0] LINE_P1_IN0  = 3'h4;
  localparam logic [2:0] LINE_P2_IN0  = 3'h0;
  localparam logic [2:0] LINE_P1_OUT0 = 3'h0;
  localparam logic [2:0] LINE_P2_OUT0 = 3'h4;
  localparam logic [2:0] LAST_BIT     = 3'h7;
  localparam logic [2:0] TAIL_BITS    = 3'h7;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_FETCH = 2'h1,
    ST_SHIFT = 2'h3
  } atsr_state_t;

endpackage : atsr_pkg

// *** include/atsr_stream_if.sv ***
// valid/ready word stream between engine and its FIFOs
// assumes both ends run on the same clock
`timescale 1ns/1ns
interface atsr_stream_if #(parameter int W = 32);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : atsr_stream_if

// *** src/atsr_fifo.sv ***
// small synchronous FIFO, depth a power of two
// assumes mclk domain, ce freezes all state
`timescale 1ns/1ns
module atsr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input  wire logic  mclk,
  input  wire logic  ce,
  input  wire logic  srst,
  atsr_stream_if.snk fill,
  atsr_stream_if.src drain
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [CW-1:0]    cnt_q;
  wire              push;
  wire              pop;

  assign fill.ready  = (cnt_q != CW'(DEPTH));
  assign drain.valid = (cnt_q != '0);
  assign drain.data  = mem[rd_q];
  assign push        = fill.valid & fill.ready;
  assign pop         = drain.valid & drain.ready;

  always_ff @(posedge mclk) begin
    if (srst) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (push) begin
        mem[wr_q] <= fill.data;
        wr_q      <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + CW'(push) - CW'(pop);
    end
  end

endmodule : atsr_fifo

// *** tb/atsr_audio_dev.sv ***
// serial audio device model on the data and bit clock lines
// assumes the bench merges line levels from all drivers into sd
`timescale 1ns/1ns
module atsr_audio_dev (
  input  wire logic       run,
  input  wire logic [4:0] sd,
  output logic            bclk,
  output logic      [4:0] devDrv
);
  logic [7:0] tx0 [0:7];
  logic [7:0] tx1 [0:7];
  logic [7:0] rx2 [0:7];
  logic [7:0] rx4 [0:7];
  int         bitN;
  int         slot;
  int         b;
  initial begin
    bclk = 1'b0;
    devDrv = 5'h00;
    bitN = 0;
  end
  // ----------------------------------------------------------------
  // bit clock only within the frame, data MSB first
  // ----------------------------------------------------------------
  always begin
    if (!run || bitN >= 64) begin
      #20;
    end else begin
      if (bitN == 0) #7;
      slot = bitN / 8;
      b = 7 - bitN % 8;
      devDrv[0] = tx0[slot][b];
      devDrv[1] = tx1[slot][b];
      // released lines toggle so a stale level never passes
      devDrv[4:2] = ~devDrv[4:2];
      #80 bclk = 1'b1;
      rx2[slot][b] = sd[2];
      rx4[slot][b] = sd[4];
      #80 bclk = 1'b0;
      bitN++;
    end
  end
endmodule : atsr_audio_dev

// *** tb/tb.sv ***
// self-checking bench for the time slot record engine
// assumes the engine's own assertions guard the pin-level timing
`timescale 1ns/1ns
`define CHK(a, e) begin checksDone++; if ((a) !== (e)) begin numErrors++; \
  $display("CHECK FAILED %0t value %0h expected %0h", $time, a, e); end end
module tb;
  import atsr_pkg::*;
  logic               mclk = 1'b0;
  logic               srst = 1'b1;
  logic [ADDR_W-1:0]  regAddr = '0;
  logic [31:0]        regWdata = '0;
  logic               regWr = 1'b0;
  logic               regRd = 1'b0;
  logic [31:0]        regRdata;
  logic [4:0]         sdOut, sdOe, wsOut, wsOe, devDrv, sdLine;
  logic [1:0]         capValid, playReady;
  logic [1:0]         capReady = 2'h0;
  logic [1:0]         playValid = 2'h0;
  logic [1:0][31:0]   capData;
  logic [1:0][31:0]   playData = '0;
  logic               bclk;
  logic               run = 1'b0;
  logic [31:0]        rd;
  logic [4:0]         wsv [0:3];
  logic [31:0]        w [0:1];
  int                 numErrors = 0;
  int                 checksDone = 0;
  int                 cyc = 0;
  int                 s;
  always #10 mclk = ~mclk;
  assign sdLine = (sdOe & sdOut) | (~sdOe & devDrv);
  atsr_engine dut (.mclk(mclk), .ce(1'b1), .srst(srst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .bclk(bclk), .sdIn(sdLine), .sdOut(sdOut), .sdOe(sdOe), .wsOut(wsOut),
    .wsOe(wsOe), .capValid(capValid), .capData(capData),
    .capReady(capReady), .playValid(playValid), .playData(playData),
    .playReady(playReady));
  atsr_audio_dev dev (.run(run), .sd(sdLine), .bclk(bclk), .devDrv(devDrv));
  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rdReg(input logic [5:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(posedge mclk);
    rd = regRdata;
  endtask : rdReg
  task automatic push(input int p, input logic [31:0] d);
    int n;
    @(posedge mclk);
    playValid[p] <= 1'b1;
    playData[p] <= d;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (playReady[p] !== 1'b1 && n < 50);
    playValid[p] <= 1'b0;
  endtask : push
  function automatic logic [11:0] fld(logic [1:0] is, int k, logic [1:0] op);
    return {is, 1'b1, 1'b0, k == 3, k == 0, k[2:0], op, 1'b0};
  endfunction : fld
  task automatic results();
    $display("errors %0d checks %0d", numErrors, checksDone);
    if (numErrors == 0 && checksDone > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      numErrors++;
      results();
    end
  end
  // ----------------------------------------------------------------
  // mid-slot pin checks
  // ----------------------------------------------------------------
  always @(posedge bclk) begin
    if (dev.bitN % 8 == 3 && dev.bitN < 40) begin
      s = dev.bitN / 8;
      #40;
      `CHK(wsOut, wsv[s % 4])
      `CHK(sdOe, 5'h14)
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(78));
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      dev.tx0[i] = $urandom;
      dev.tx1[i] = $urandom;
    end
    for (int k = 0; k < 4; k++) begin
      wsv[k] = $urandom;
      // port one: in line 1, out line 2; port two: in line 0, out line 4
      wr(k[5:0], {wsv[k][0], wsv[k][1], wsv[k][2], wsv[k][3], wsv[k][4],
        1'b0, fld(2'h1, k, 2'h2), 1'b0, fld(2'h0, k, 2'h0), k == 3});
    end
    rdReg(6'h02);
    `CHK(rd, 32'h00000000)
    rdReg(6'h3F);
    `CHK(rd, 32'h00000000)
    for (int p = 0; p < 2; p++) begin
      w[p] = $urandom;
      push(p, w[p]);
      for (int i = 1; i < FIFO_DEPTH; i++) push(p, $urandom);
      @(posedge mclk);
      `CHK(playReady[p], 1'b0)
    end
    wr(ADDR_CTRL, 32'h00000003);
    run <= 1'b1;
    for (int n = 0; n < 5000 && dev.bitN < 44; n++) @(posedge mclk);
    `CHK(capValid, 2'h3)
    `CHK(capData[0], {dev.tx1[3], dev.tx1[2], dev.tx1[1], dev.tx1[0]})
    `CHK(capData[1], {dev.tx0[3], dev.tx0[2], dev.tx0[1], dev.tx0[0]})
    for (int k = 1; k < 5; k++) begin
      `CHK(dev.rx2[k], w[0][8*(k%4) +: 8])
      `CHK(dev.rx4[k], w[1][8*(k%4) +: 8])
    end
    @(posedge mclk);
    capReady <= 2'h3;
    @(posedge mclk);
    capReady <= 2'h0;
    repeat (2) @(posedge mclk);
    `CHK(capValid, 2'h0)
    results();
  end
endmodule : tb
